// >>> stereo_mode_pkg.sv
// shared constants and types for the stereo mode select controller
package stereo_mode_pkg;

   typedef enum logic [1:0] {
      MODE_LEFT,
      MODE_RIGHT,
      MODE_BYPASS,
      MODE_AUTO
   } mode_e;

   // one bit per command line
   typedef struct packed {
      logic left_source_synthesis;
      logic right_source_synthesis;
      logic bypass;
      logic auto_mode;
      logic comb_wide;
      logic comb_narrow;
      logic nr_operate;
      logic nr_defeat;
   } cmd_s;

   typedef struct packed {
      logic left;
      logic right;
      logic bypass;
      logic auto_mode;
   } lamp_s;

   localparam int CMD_WIDTH = 8;
   localparam int CLK_FREQ_HZ = 20_000_000;
   localparam int DEBOUNCE_US = 5000;
   localparam int DEBOUNCE_CYCLES = (CLK_FREQ_HZ / 1000) * DEBOUNCE_US / 1000;
   localparam int FAST_FADE_MS = 100;
   localparam int SLOW_FADE_MS = 2000;
   localparam int FAST_FADE_CYCLES = (CLK_FREQ_HZ / 1000) * FAST_FADE_MS;
   localparam int SLOW_FADE_CYCLES = (CLK_FREQ_HZ / 1000) * SLOW_FADE_MS;
   localparam int DEBOUNCE_CNT_W = 17;
   localparam int FADE_CNT_W = 26;

   localparam mode_e RESET_MODE = MODE_BYPASS;
   localparam logic RESET_COMB_WIDE = 1'b0;
   localparam logic RESET_NR_ON = 1'b1;
   localparam logic RESET_INHIBIT = 1'b0;

endpackage

// >>> input_conditioner.sv
// two-flop synchroniser, debouncer and rising-edge detector for one input
`timescale 1ns/100ps
`default_nettype none
module input_conditioner
   import stereo_mode_pkg::*;
#(
   parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire logic raw_in,
   output logic level_out,
   output logic rise_out
);
   logic sync1_reg;
   logic sync2_reg;
   logic stable_reg;
   logic rise_reg;
   logic [DEBOUNCE_CNT_W-1:0] count_reg;
   logic [DEBOUNCE_CNT_W-1:0] count_next;
   wire logic differs;
   wire logic settled;

   assign differs = sync2_reg != stable_reg;
   assign settled = differs && (count_reg == DEBOUNCE_CNT_W'(DEBOUNCE_LEN - 1));
   assign count_next = differs ? count_reg + 1'b1 : '0;

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         stable_reg <= 1'b0;
         rise_reg <= 1'b0;
         count_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
         count_reg <= settled ? '0 : count_next;
         if (settled) begin
            stable_reg <= sync2_reg;
         end
         rise_reg <= settled && sync2_reg;
      end
   end

   assign level_out = stable_reg;
   assign rise_out = rise_reg;
endmodule
`default_nettype wire

// >>> stereo_mode_select_control.sv
// mode selection, lockout, crossfade speed and setting latches of the synthesizer
`timescale 1ns/100ps
`default_nettype none
module stereo_mode_select_control
   import stereo_mode_pkg::*;
#(
   parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES,
   parameter int FAST_FADE_LEN = FAST_FADE_CYCLES,
   parameter int SLOW_FADE_LEN = SLOW_FADE_CYCLES
) (
   input wire logic ref_clk_in,
   input wire logic reset_in,
   input wire cmd_s panel_in,
   input wire cmd_s remote_in,
   input wire cmd_s automation_in,
   input wire logic inhibit_button_in,
   input wire logic pulse_style_in,
   input wire logic single_channel_recognition_only_in,
   input wire logic left_audio_present_in,
   input wire logic right_audio_present_in,
   input wire logic center_detected_in,
   input wire logic expansion_active_in,
   output lamp_s active_lamp_out,
   output lamp_s standby_lamp_out,
   output logic inhibit_lamp_out,
   output logic comb_wide_out,
   output logic nr_on_out,
   output logic expansion_lamp_out,
   output logic fade_slow_out,
   output logic fading_out,
   output logic automation_error_out
);
   // ************************************************************
   // input conditioning
   // ************************************************************
   localparam int NSRC = 3 * CMD_WIDTH + 1;
   wire logic [NSRC-1:0] raw_all;
   wire logic [NSRC-1:0] lvl_all;
   wire logic [NSRC-1:0] rise_all;

   assign raw_all = {inhibit_button_in, automation_in, remote_in, panel_in};

   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_cond
         input_conditioner #(
            .DEBOUNCE_LEN(DEBOUNCE_LEN)
         ) u_cond (
            .ref_clk_in(ref_clk_in),
            .reset_in(reset_in),
            .raw_in(raw_all[gi]),
            .level_out(lvl_all[gi]),
            .rise_out(rise_all[gi])
         );
      end
   endgenerate

   // the style and recognition straps are slow switches, synchronised only
   logic [2:0] strap_s1_reg;
   logic [2:0] strap_s2_reg;
   logic [4:0] det_s1_reg;
   logic [4:0] det_s2_reg;
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         strap_s1_reg <= '0;
         strap_s2_reg <= '0;
         det_s1_reg <= '0;
         det_s2_reg <= '0;
      end else begin
         strap_s1_reg <= {pulse_style_in, single_channel_recognition_only_in, 1'b0};
         strap_s2_reg <= strap_s1_reg;
         det_s1_reg <= {left_audio_present_in, right_audio_present_in,
                        center_detected_in, expansion_active_in, 1'b0};
         det_s2_reg <= det_s1_reg;
      end
   end

   wire logic pulsed;
   wire logic single_only;
   wire logic left_aud;
   wire logic right_aud;
   wire logic center;
   wire logic expansion;
   assign pulsed = strap_s2_reg[2];
   assign single_only = strap_s2_reg[1];
   assign left_aud = det_s2_reg[4];
   assign right_aud = det_s2_reg[3];
   assign center = det_s2_reg[2];
   assign expansion = det_s2_reg[1];

   wire cmd_s pan_rise;
   wire cmd_s rem_rise;
   wire cmd_s aut_rise;
   wire cmd_s aut_lvl;
   wire logic inhibit_rise;
   assign pan_rise = cmd_s'(rise_all[CMD_WIDTH-1:0]);
   assign rem_rise = cmd_s'(rise_all[2*CMD_WIDTH-1:CMD_WIDTH]);
   assign aut_rise = cmd_s'(rise_all[3*CMD_WIDTH-1:2*CMD_WIDTH]);
   assign aut_lvl = cmd_s'(lvl_all[3*CMD_WIDTH-1:2*CMD_WIDTH]);
   assign inhibit_rise = rise_all[NSRC-1];

   // ************************************************************
   // decoding helpers
   // ************************************************************
   function automatic logic [2:0] count_modes(input cmd_s c);
      count_modes = 3'(c.left_source_synthesis) + 3'(c.right_source_synthesis)
                  + 3'(c.bypass) + 3'(c.auto_mode);
   endfunction

   // priority pick of one mode bit; valid only when some bit set
   function automatic mode_e pick_mode(input cmd_s c);
      if (c.left_source_synthesis) begin
         pick_mode = MODE_LEFT;
      end else if (c.right_source_synthesis) begin
         pick_mode = MODE_RIGHT;
      end else if (c.bypass) begin
         pick_mode = MODE_BYPASS;
      end else begin
         pick_mode = MODE_AUTO;
      end
   endfunction

   // ************************************************************
   // mode state
   // ************************************************************
   mode_e standby_reg;
   mode_e active_reg;
   logic inhibit_reg;
   logic inhibit_next;
   logic ext_active_reg;

   assign inhibit_next = inhibit_reg ^ inhibit_rise;

   // automation mode lines only count while not inhibited; automation setting commands and remote are never gated
   wire logic ext_enable;
   wire cmd_s aut_lvl_g;
   wire cmd_s aut_rise_g;
   assign ext_enable = !inhibit_reg && !inhibit_rise;
   assign aut_lvl_g = ext_enable ? aut_lvl : cmd_s'('0);
   assign aut_rise_g = ext_enable ? aut_rise : cmd_s'('0);

   // continuous style: auto line is not a valid override
   wire logic [2:0] lvl_count;
   wire logic cont_override;
   wire mode_e cont_mode;
   assign lvl_count = count_modes(aut_lvl_g);
   assign cont_override = !pulsed && (aut_lvl_g.left_source_synthesis
      || aut_lvl_g.right_source_synthesis || aut_lvl_g.bypass);
   assign cont_mode = pick_mode(aut_lvl_g);

   // error: two or more mode lines active together
   wire logic auto_error;
   assign auto_error = lvl_count >= 3'h2;

   // a button (panel or remote) or a pulse acts the same way
   wire cmd_s press;
   wire logic press_any;
   wire mode_e press_mode;
   assign press = cmd_s'(pan_rise | rem_rise | (pulsed ? aut_rise_g : cmd_s'('0)));
   assign press_any = press.left_source_synthesis || press.right_source_synthesis
      || press.bypass || press.auto_mode;
   assign press_mode = pick_mode(press);

   // standby lamps show while a line holds the device
   wire logic override_now;
   assign override_now = cont_override || (!pulsed && aut_lvl_g.auto_mode) || auto_error;

   // auto recognition decision
   logic auto_change;
   mode_e auto_target;
   logic auto_slow;
   always_comb begin
      auto_change = 1'b1;
      auto_target = MODE_BYPASS;
      auto_slow = 1'b0;
      if (left_aud && !right_aud) begin
         auto_target = MODE_LEFT;
      end else if (right_aud && !left_aud) begin
         auto_target = MODE_RIGHT;
      end else if (!left_aud && !right_aud) begin
         auto_change = 1'b0;
      end else if (single_only) begin
         auto_target = MODE_BYPASS;
      end else begin
         auto_target = center ? MODE_LEFT : MODE_BYPASS;
         auto_slow = 1'b1;
      end
   end

   // effective synthesis state: auto resolves to its recognised mode
   mode_e recog_reg;
   mode_e effective_now;
   logic manual_change;
   mode_e active_next;
   mode_e standby_next;
   always_comb begin
      standby_next = standby_reg;
      active_next = active_reg;
      manual_change = 1'b0;
      if (press_any) begin
         standby_next = press_mode;
      end
      if (auto_error) begin
         active_next = MODE_AUTO;
      end else if (cont_override) begin
         active_next = cont_mode;
      end else begin
         active_next = standby_next;
      end
      manual_change = active_next != active_reg && active_next != MODE_AUTO;
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         standby_reg <= RESET_MODE;
         active_reg <= RESET_MODE;
         inhibit_reg <= RESET_INHIBIT;
         ext_active_reg <= 1'b0;
         recog_reg <= MODE_BYPASS;
      end else begin
         standby_reg <= standby_next;
         active_reg <= active_next;
         inhibit_reg <= inhibit_next;
         ext_active_reg <= override_now;
         if (auto_change) begin
            recog_reg <= auto_target;
         end
      end
   end
   assign effective_now = (active_reg == MODE_AUTO) ? recog_reg : active_reg;

   // ************************************************************
   // crossfade timer
   // ************************************************************
   logic [FADE_CNT_W-1:0] fade_cnt_reg;
   logic fade_slow_reg;
   logic fading_reg;
   mode_e last_eff_reg;
   wire logic eff_changed;
   wire logic auto_fade_slow;
   assign eff_changed = effective_now != last_eff_reg;
   assign auto_fade_slow = (active_reg == MODE_AUTO) && auto_slow && !manual_change;

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         fade_cnt_reg <= '0;
         fade_slow_reg <= 1'b0;
         fading_reg <= 1'b0;
         last_eff_reg <= RESET_MODE;
      end else begin
         last_eff_reg <= effective_now;
         // registered copy of a non-zero count, so the lamp needs no decoder after a flop
         fading_reg <= eff_changed || (fade_cnt_reg > FADE_CNT_W'(1));
         if (eff_changed) begin
            fade_slow_reg <= auto_fade_slow;
            fade_cnt_reg <= auto_fade_slow ? FADE_CNT_W'(SLOW_FADE_LEN)
                                           : FADE_CNT_W'(FAST_FADE_LEN);
         end else if (fade_cnt_reg != '0) begin
            fade_cnt_reg <= fade_cnt_reg - 1'b1;
         end
      end
   end

   // ************************************************************
   // setting latches and lamps
   // ************************************************************
   wire cmd_s set_req;
   assign set_req = cmd_s'(pan_rise | rem_rise | aut_rise);

   logic comb_wide_reg;
   logic nr_on_reg;
   logic expansion_reg;
   lamp_s active_lamp_reg;
   lamp_s standby_lamp_reg;
   logic error_reg;

   function automatic lamp_s lamp_of(input mode_e m);
      lamp_of = '{left: m == MODE_LEFT, right: m == MODE_RIGHT,
                  bypass: m == MODE_BYPASS, auto_mode: m == MODE_AUTO};
   endfunction

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         comb_wide_reg <= RESET_COMB_WIDE;
         nr_on_reg <= RESET_NR_ON;
         expansion_reg <= 1'b0;
         active_lamp_reg <= lamp_of(RESET_MODE);
         standby_lamp_reg <= '0;
         error_reg <= 1'b0;
      end else begin
         if (set_req.comb_wide) begin
            comb_wide_reg <= 1'b1;
         end else if (set_req.comb_narrow) begin
            comb_wide_reg <= 1'b0;
         end
         if (set_req.nr_operate) begin
            nr_on_reg <= 1'b1;
         end else if (set_req.nr_defeat) begin
            nr_on_reg <= 1'b0;
         end
         // expansion only matters while synthesis is in effect
         expansion_reg <= nr_on_reg && expansion && (effective_now != MODE_BYPASS);
         active_lamp_reg <= lamp_of(active_reg);
         standby_lamp_reg <= ext_active_reg ? lamp_of(standby_reg) : lamp_s'('0);
         error_reg <= auto_error;
      end
   end

   assign active_lamp_out = active_lamp_reg;
   assign standby_lamp_out = standby_lamp_reg;
   assign inhibit_lamp_out = inhibit_reg;
   assign comb_wide_out = comb_wide_reg;
   assign nr_on_out = nr_on_reg;
   assign expansion_lamp_out = expansion_reg;
   assign fade_slow_out = fade_slow_reg;
   assign fading_out = fading_reg;
   assign automation_error_out = error_reg;

   // ************************************************************
   // checks
   // ************************************************************
   property p_error_auto;
      @(posedge ref_clk_in) disable iff (reset_in) auto_error |=> active_reg == MODE_AUTO;
   endproperty
   a_error_auto: assert property (p_error_auto) else $error("error not to auto");

   property p_inhibit_toggle;
      @(posedge ref_clk_in) disable iff (reset_in) inhibit_rise |=> inhibit_reg != $past(inhibit_reg);
   endproperty
   a_inhibit_toggle: assert property (p_inhibit_toggle) else $error("inhibit no toggle");

   property p_standby_dark;
      @(posedge ref_clk_in) disable iff (reset_in) !ext_active_reg |=> standby_lamp_out == '0;
   endproperty
   a_standby_dark: assert property (p_standby_dark) else $error("standby lamp lit");

   property p_active_lamp;
      @(posedge ref_clk_in) disable iff (reset_in) ##1 active_lamp_out == lamp_of($past(active_reg));
   endproperty
   a_active_lamp: assert property (p_active_lamp) else $error("active lamp wrong");

   property p_press_free;
      @(posedge ref_clk_in) disable iff (reset_in)
         press_any && !cont_override && !auto_error |=> active_reg == $past(press_mode);
   endproperty
   a_press_free: assert property (p_press_free) else $error("press not applied");

   property p_override_holds;
      @(posedge ref_clk_in) disable iff (reset_in)
         cont_override && !auto_error |=> active_reg == $past(cont_mode);
   endproperty
   a_override_holds: assert property (p_override_holds) else $error("override lost");

   property p_inhibit_blocks;
      @(posedge ref_clk_in) disable iff (reset_in) inhibit_reg |-> !cont_override && !auto_error;
   endproperty
   a_inhibit_blocks: assert property (p_inhibit_blocks) else $error("lines not blocked");

   property p_fast_fade;
      @(posedge ref_clk_in) disable iff (reset_in)
         eff_changed && !auto_fade_slow |=> fade_cnt_reg == FADE_CNT_W'(FAST_FADE_LEN);
   endproperty
   a_fast_fade: assert property (p_fast_fade) else $error("fast fade length");
endmodule
`default_nettype wire

// >>> automation_driver.sv
// behavioural model of the broadcast automation that drives the command lines
`timescale 1ns/100ps
`default_nettype none
module automation_driver
   import stereo_mode_pkg::*;
#(
   parameter int PULSE_LEN = 10
) (
   input wire logic ref_clk_in,
   input wire logic pulse_style_in,
   input wire cmd_s request_in,
   output cmd_s lines_out
);
   // ****************************************
   // pulse generation
   // ****************************************
   cmd_s last_req = '0;
   cmd_s pulse_val = '0;
   int pulse_left = 0;
   // one pulse per new command, long enough to outlast the debouncer
   always @(negedge ref_clk_in) begin
      if (request_in != last_req && request_in != '0) begin
         pulse_val <= request_in;
         pulse_left <= PULSE_LEN;
      end else if (pulse_left > 0) begin
         pulse_left <= pulse_left - 1;
      end
      last_req <= request_in;
   end
   // continuous style simply holds the line for as long as it is requested
   assign lines_out = pulse_style_in ? ((pulse_left > 0) ? pulse_val : cmd_s'('0)) : request_in;
endmodule
`default_nettype wire

// >>> stereo_mode_select_control_tb.sv
// self-checking testbench for the stereo mode select controller
`timescale 1ns/100ps
`default_nettype none
module stereo_mode_select_control_tb;
   import stereo_mode_pkg::*;
   // ****************************************
   // stimulus and observation signals
   // ****************************************
   localparam lamp_s DARK = 4'h0;
   localparam lamp_s L_LEFT = 4'h8;
   localparam lamp_s L_RIGHT = 4'h4;
   localparam lamp_s L_BYP = 4'h2;
   localparam lamp_s L_AUTO = 4'h1;
   localparam cmd_s C_LEFT = 8'h80;
   localparam cmd_s C_RIGHT = 8'h40;
   localparam cmd_s C_BYP = 8'h20;
   localparam cmd_s C_AUTO = 8'h10;
   localparam cmd_s C_WIDE = 8'h08;
   localparam cmd_s C_NARROW = 8'h04;
   localparam cmd_s C_NRON = 8'h02;
   localparam cmd_s C_NROFF = 8'h01;
   logic ref_clk_in = 1'b0;
   logic reset_in = 1'b1;
   cmd_s panel_in = '0;
   cmd_s remote_in = '0;
   cmd_s request = '0;
   cmd_s lines;
   logic inhibit_btn = 1'b0;
   logic pulse_style = 1'b0;
   logic single_only = 1'b1;
   logic left_audio = 1'b0;
   logic right_audio = 1'b0;
   logic center = 1'b0;
   logic expansion = 1'b0;
   lamp_s active_lamp;
   lamp_s standby_lamp;
   logic inhibit_lamp, comb_wide, nr_on, expansion_lamp, fade_slow, fading, auto_error;
   int n_mismatch = 0;
   int samples_checked = 0;

   always #25 ref_clk_in = ~ref_clk_in;

   stereo_mode_select_control #(
      .DEBOUNCE_LEN(4),
      .FAST_FADE_LEN(10),
      .SLOW_FADE_LEN(40)
   ) stereo_mode_select_control_i (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .panel_in(panel_in),
      .remote_in(remote_in),
      .automation_in(lines),
      .inhibit_button_in(inhibit_btn),
      .pulse_style_in(pulse_style),
      .single_channel_recognition_only_in(single_only),
      .left_audio_present_in(left_audio),
      .right_audio_present_in(right_audio),
      .center_detected_in(center),
      .expansion_active_in(expansion),
      .active_lamp_out(active_lamp),
      .standby_lamp_out(standby_lamp),
      .inhibit_lamp_out(inhibit_lamp),
      .comb_wide_out(comb_wide),
      .nr_on_out(nr_on),
      .expansion_lamp_out(expansion_lamp),
      .fade_slow_out(fade_slow),
      .fading_out(fading),
      .automation_error_out(auto_error)
   );

   automation_driver #(.PULSE_LEN(10)) automation_driver_i (
      .ref_clk_in(ref_clk_in),
      .pulse_style_in(pulse_style),
      .request_in(request),
      .lines_out(lines)
   );

   // ****************************************
   // access tasks and comparisons
   // ****************************************
   task automatic cycles(input int n);
      repeat (n) @(negedge ref_clk_in);
   endtask

   task automatic cmp_lamp(input string what, input lamp_s exp, input lamp_s got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   // press and release, each held well past the debounce length
   task automatic press(input int src, input cmd_s c);
      if (src == 0) panel_in = c;
      else remote_in = c;
      cycles(20);
      panel_in = '0;
      remote_in = '0;
      cycles(20);
   endtask

   // non-blocking so the model sees the change one falling edge later, without a race
   task automatic drive(input cmd_s c);
      request <= c;
      cycles(20);
   endtask

   task automatic toggle_inhibit;
      inhibit_btn = 1'b1;
      cycles(20);
      inhibit_btn = 1'b0;
      cycles(20);
   endtask

   task automatic finish_test;
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      cycles(2);
      reset_in = 1'b0;
      cycles(2);
      cmp_lamp("active", L_BYP, active_lamp);
      cmp_lamp("standby", DARK, standby_lamp);
      cmp_bit("inhibit", 1'b0, inhibit_lamp);
      cmp_bit("comb_wide", 1'b0, comb_wide);
      cmp_bit("nr_on", 1'b1, nr_on);
      // manual selection starts a fast crossfade
      panel_in = C_LEFT;
      cycles(12);
      cmp_bit("fading", 1'b1, fading);
      cmp_bit("fade_slow", 1'b0, fade_slow);
      cycles(8);
      panel_in = '0;
      cycles(20);
      cmp_lamp("active", L_LEFT, active_lamp);
      // automatic recognition
      press(0, C_AUTO);
      cmp_lamp("active", L_AUTO, active_lamp);
      left_audio = 1'b1;
      cycles(20);
      cmp_bit("fade_slow", 1'b0, fade_slow);
      right_audio = 1'b1;
      single_only = 1'b0;
      cycles(20);
      cmp_bit("fading", 1'b1, fading);
      cmp_bit("fade_slow", 1'b1, fade_slow);
      cycles(40);
      center = 1'b1;
      cycles(20);
      cmp_bit("fading", 1'b1, fading);
      cycles(40);
      single_only = 1'b1;
      cycles(20);
      cmp_bit("fade_slow", 1'b0, fade_slow);
      left_audio = 1'b0;
      right_audio = 1'b0;
      cycles(8);
      cmp_bit("fading", 1'b0, fading);
      cmp_lamp("active", L_AUTO, active_lamp);
      // continuous automation override
      drive(C_RIGHT);
      cmp_lamp("active", L_RIGHT, active_lamp);
      cmp_lamp("standby", L_AUTO, standby_lamp);
      press(0, C_BYP);
      cmp_lamp("standby", L_BYP, standby_lamp);
      cmp_lamp("active", L_RIGHT, active_lamp);
      drive('0);
      cmp_lamp("active", L_BYP, active_lamp);
      cmp_lamp("standby", DARK, standby_lamp);
      drive(C_AUTO);
      cmp_lamp("active", L_BYP, active_lamp);
      drive('0);
      drive(C_LEFT | C_RIGHT);
      cmp_lamp("active", L_AUTO, active_lamp);
      cmp_bit("error", 1'b1, auto_error);
      drive('0);
      cmp_lamp("active", L_BYP, active_lamp);
      cmp_bit("error", 1'b0, auto_error);
      // lockout of the automation lines
      drive(C_RIGHT);
      toggle_inhibit();
      cmp_bit("inhibit", 1'b1, inhibit_lamp);
      cmp_lamp("active", L_BYP, active_lamp);
      drive(C_LEFT | C_WIDE);
      cmp_lamp("active", L_BYP, active_lamp);
      cmp_bit("comb_wide", 1'b1, comb_wide);
      press(1, C_LEFT);
      cmp_lamp("active", L_LEFT, active_lamp);
      press(0, C_AUTO);
      cmp_lamp("active", L_AUTO, active_lamp);
      drive('0);
      toggle_inhibit();
      cmp_bit("inhibit", 1'b0, inhibit_lamp);
      toggle_inhibit();
      cmp_lamp("active", L_AUTO, active_lamp);
      toggle_inhibit();
      press(0, C_NARROW);
      cmp_bit("comb_wide", 1'b0, comb_wide);
      // pulsed automation
      pulse_style = 1'b1;
      cycles(4);
      drive(C_LEFT);
      drive('0);
      cmp_lamp("active", L_LEFT, active_lamp);
      expansion = 1'b1;
      press(0, C_NROFF);
      cmp_bit("nr_on", 1'b0, nr_on);
      cmp_bit("expansion", 1'b0, expansion_lamp);
      drive(C_NRON);
      drive('0);
      cmp_bit("nr_on", 1'b1, nr_on);
      cmp_bit("expansion", 1'b1, expansion_lamp);
      drive(C_AUTO);
      drive('0);
      cmp_lamp("active", L_AUTO, active_lamp);
      drive(C_BYP);
      drive('0);
      cmp_lamp("active", L_BYP, active_lamp);
      finish_test();
   end
endmodule
`default_nettype wire
